// ---- cc_rx_alarm_pkg.sv ----
// Constants for the receive clear-channel alarm and status block.
// Assumes a 32-bit APB slave port with byte addresses.
package cc_rx_alarm_pkg;

   // ----------------------------------------------------------------
   // Bus and data widths and buffer depth
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int BUS_W = 32;
   localparam int REG_W = 16;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] RX_CLEAR_CHANNEL_CONTROL = 8'h20;
   localparam logic [ADDR_W-1:0] RX_CLEAR_CHANNEL_LIVE_STATUS = 8'h24;
   localparam logic [ADDR_W-1:0] RX_CLEAR_CHANNEL_LATCHED_STATUS = 8'h28;
   localparam logic [ADDR_W-1:0] RX_CLEAR_CHANNEL_IRQ_ENABLE = 8'h2C;

   // ----------------------------------------------------------------
   // Field positions and reset value
   // ----------------------------------------------------------------
   localparam int MANUAL_ALARM_INSERT_BIT = 12;
   localparam int AUTO_ALARM_DISABLE_BIT = 11;
   localparam int UNFRAMED_ALL_ONES_BIT = 8;
   localparam int SIGNAL_LOSS_BIT = 0;
   localparam logic [REG_W-1:0] REG_RESET = 16'h0000;

endpackage

// ---- cc_rx_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; DEPTH must be a power of two.
`timescale 1ns/1ns
module cc_rx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("cc_rx_fifo: DEPTH must be a power of two, at least 2");
      end
   endgenerate

   typedef struct packed {
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0] count;
      logic notFull;
   } fifo_state_t;

   // Empty and ready to take a word as reset lets go
   localparam fifo_state_t RESET_STATE = '{wrPtr: '0, rdPtr: '0, count: '0, notFull: 1'b1};

   fifo_state_t state_q;
   fifo_state_t state_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign inReady = state_q.notFull;
   assign outValid = (state_q.count != '0);
   assign outData = mem[state_q.rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb begin
      state_d = state_q;
      if (push) begin
         state_d.wrPtr = state_q.wrPtr + 1'b1;
      end
      if (pop) begin
         state_d.rdPtr = state_q.rdPtr + 1'b1;
      end
      if (push && !pop) begin
         state_d.count = state_q.count + 1'b1;
      end else if (pop && !push) begin
         state_d.count = state_q.count - 1'b1;
      end
      // Registered so the line side sees ready straight from a flop
      state_d.notFull = (state_d.count != FULL_COUNT);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= RESET_STATE;
      end else begin
         state_q <= state_d;
      end
   end

   // Storage needs no reset; only occupied words are ever read out
   always_ff @(posedge clk) begin
      if (push) begin
         mem[state_q.wrPtr] <= inData;
      end
   end
endmodule

// ---- cc_rx_alarm_monitor.sv ----
// Receive clear-channel alarm monitor: live status, change flags,
// interrupt enables and downstream all-ones alarm insertion.
// Assumes an APB master on the register port and synchronous pins.
`timescale 1ns/1ns

// Overview of operation
// - Manual control bit forces downstream alarm insertion
// - Signal loss inserts alarm unless auto-disable set
// - All-ones status bit follows detector condition
// - Loss status bit follows the loss input pin
// - All-ones flag latches on any status change
// - Loss flag latches on any status change
// - Enabled all-ones flag raises interrupt request
// - Enabled loss flag raises interrupt request
// - Inserted alarm forces downstream data all ones
module cc_rx_alarm_monitor #(
   parameter int DATA_W = cc_rx_alarm_pkg::DATA_W,
   parameter int FIFO_DEPTH = cc_rx_alarm_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [cc_rx_alarm_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cc_rx_alarm_pkg::BUS_W-1:0] pwdata,
   output logic [cc_rx_alarm_pkg::BUS_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic signal_loss_input_pin,
   input wire logic unframedAllOnesIn,
   input wire logic rxValid,
   output logic rxReady,
   input wire logic [DATA_W-1:0] rxData,
   output logic dnValid,
   input wire logic dnReady,
   output logic [DATA_W-1:0] dnData,
   output logic irqReq
);
   import cc_rx_alarm_pkg::*;

   generate
      if (DATA_W < 1 || FIFO_DEPTH < 2) begin : g_bad_param
         $error("cc_rx_alarm_monitor: DATA_W >= 1 and FIFO_DEPTH >= 2 required");
      end
   endgenerate

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic manual_alarm_insert;
      logic auto_alarm_on_signal_loss_disable;
      logic unframed_all_ones_status;
      logic signalLossStatus;
      logic unframed_all_ones_change_flag;
      logic signal_loss_change_flag;
      logic unframed_all_ones_irq_enable;
      logic signal_loss_irq_enable;
      logic [BUS_W-1:0] rdData;
      logic ready;
      logic slvErr;
      logic irq;
      logic outValid;
      logic [DATA_W-1:0] outData;
   } mon_state_t;

   mon_state_t state_q;
   mon_state_t state_d;

   logic fifoValid;
   logic fifoPop;
   logic [DATA_W-1:0] fifoData;
   logic insertAlarm;
   logic access;
   logic wrDone;
   logic [REG_W-1:0] wrBits;

   function automatic logic hits(input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] offset);
      hits = (addr == offset);
   endfunction

   // Reserved offsets between the registers answer with an error
   function automatic logic mapped(input logic [ADDR_W-1:0] addr);
      mapped = hits(addr, RX_CLEAR_CHANNEL_CONTROL) ||
               hits(addr, RX_CLEAR_CHANNEL_LIVE_STATUS) ||
               hits(addr, RX_CLEAR_CHANNEL_LATCHED_STATUS) ||
               hits(addr, RX_CLEAR_CHANNEL_IRQ_ENABLE);
   endfunction

   // ----------------------------------------------------------------
   // Data path buffer
   // ----------------------------------------------------------------
   // Words wait here while the sink stalls; the alarm stage sits behind it
   cc_rx_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) cc_rx_fifo_i (
      .clk(clk),
      .rst(rst),
      .inValid(rxValid),
      .inReady(rxReady),
      .inData(rxData),
      .outValid(fifoValid),
      .outReady(!state_q.outValid || dnReady),
      .outData(fifoData)
   );

   assign fifoPop = fifoValid && (!state_q.outValid || dnReady);
   assign insertAlarm = state_q.manual_alarm_insert ||
      (state_q.signalLossStatus && !state_q.auto_alarm_on_signal_loss_disable);
   // One wait state: the answer comes in the second access cycle
   assign access = psel && penable;
   assign wrDone = access && state_q.ready && pwrite;
   assign wrBits = pwdata[REG_W-1:0];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      // Live status follows the pins one cycle late
      state_d.unframed_all_ones_status = unframedAllOnesIn;
      state_d.signalLossStatus = signal_loss_input_pin;

      // Software clear first so that a change in the same cycle wins
      if (wrDone && hits(paddr, RX_CLEAR_CHANNEL_LATCHED_STATUS)) begin
         if (wrBits[UNFRAMED_ALL_ONES_BIT]) begin
            state_d.unframed_all_ones_change_flag = 1'b0;
         end
         if (wrBits[SIGNAL_LOSS_BIT]) begin
            state_d.signal_loss_change_flag = 1'b0;
         end
      end
      if (unframedAllOnesIn != state_q.unframed_all_ones_status) begin
         state_d.unframed_all_ones_change_flag = 1'b1;
      end
      if (signal_loss_input_pin != state_q.signalLossStatus) begin
         state_d.signal_loss_change_flag = 1'b1;
      end

      if (wrDone && hits(paddr, RX_CLEAR_CHANNEL_CONTROL)) begin
         state_d.manual_alarm_insert = wrBits[MANUAL_ALARM_INSERT_BIT];
         state_d.auto_alarm_on_signal_loss_disable = wrBits[AUTO_ALARM_DISABLE_BIT];
      end
      if (wrDone && hits(paddr, RX_CLEAR_CHANNEL_IRQ_ENABLE)) begin
         state_d.unframed_all_ones_irq_enable = wrBits[UNFRAMED_ALL_ONES_BIT];
         state_d.signal_loss_irq_enable = wrBits[SIGNAL_LOSS_BIT];
      end

      // Level request; it drops a cycle after its flag or enable clears
      state_d.irq = (state_q.unframed_all_ones_change_flag &&
                     state_q.unframed_all_ones_irq_enable) ||
                    (state_q.signal_loss_change_flag &&
                     state_q.signal_loss_irq_enable);

      // Read data is captured in the wait cycle and shown with pready
      state_d.ready = access && !state_q.ready;
      state_d.slvErr = access && !state_q.ready && !mapped(paddr);
      state_d.rdData = '0;
      if (access && !state_q.ready && !pwrite) begin
         if (hits(paddr, RX_CLEAR_CHANNEL_CONTROL)) begin
            state_d.rdData[MANUAL_ALARM_INSERT_BIT] = state_q.manual_alarm_insert;
            state_d.rdData[AUTO_ALARM_DISABLE_BIT] =
               state_q.auto_alarm_on_signal_loss_disable;
         end else if (hits(paddr, RX_CLEAR_CHANNEL_LIVE_STATUS)) begin
            state_d.rdData[UNFRAMED_ALL_ONES_BIT] = state_q.unframed_all_ones_status;
            state_d.rdData[SIGNAL_LOSS_BIT] = state_q.signalLossStatus;
         end else if (hits(paddr, RX_CLEAR_CHANNEL_LATCHED_STATUS)) begin
            state_d.rdData[UNFRAMED_ALL_ONES_BIT] = state_q.unframed_all_ones_change_flag;
            state_d.rdData[SIGNAL_LOSS_BIT] = state_q.signal_loss_change_flag;
         end else if (hits(paddr, RX_CLEAR_CHANNEL_IRQ_ENABLE)) begin
            state_d.rdData[UNFRAMED_ALL_ONES_BIT] = state_q.unframed_all_ones_irq_enable;
            state_d.rdData[SIGNAL_LOSS_BIT] = state_q.signal_loss_irq_enable;
         end
      end

      // Alarm is applied as a word leaves the buffer; a word already
      // in the output stage goes out unchanged
      if (fifoPop) begin
         state_d.outValid = 1'b1;
         state_d.outData = insertAlarm ? {DATA_W{1'b1}} : fifoData;
      end else if (dnReady) begin
         state_d.outValid = 1'b0;
      end
   end

   // Every field, live status included, clears to zero in reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = state_q.rdData;
   assign pready = state_q.ready;
   assign pslverr = state_q.slvErr;
   assign dnValid = state_q.outValid;
   assign dnData = state_q.outData;
   assign irqReq = state_q.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // ----------------------------------------------------------------
   // Checks: register port
   // ----------------------------------------------------------------
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   rdata_idle_a: assert property (!pready |-> prdata == '0)
      else $error("read data shown outside a transfer end");
   ctrl_write_a: assert property (
      wrDone && hits(paddr, RX_CLEAR_CHANNEL_CONTROL)
      |=> state_q.manual_alarm_insert == $past(wrBits[MANUAL_ALARM_INSERT_BIT]))
      else $error("control write did not land");
   en_write_a: assert property (
      wrDone && hits(paddr, RX_CLEAR_CHANNEL_IRQ_ENABLE)
      |=> state_q.unframed_all_ones_irq_enable == $past(wrBits[UNFRAMED_ALL_ONES_BIT]))
      else $error("enable write did not land");

   // ----------------------------------------------------------------
   // Checks: alarms and flags
   // ----------------------------------------------------------------
   manual_alarm_a: assert property (
      fifoPop && state_q.manual_alarm_insert |=> dnValid && dnData == {DATA_W{1'b1}})
      else $error("manual alarm did not force ones");
   auto_alarm_a: assert property (
      fifoPop && state_q.signalLossStatus && !state_q.auto_alarm_on_signal_loss_disable
      |=> dnData == {DATA_W{1'b1}})
      else $error("signal loss did not force ones");
   data_pass_a: assert property (
      fifoPop && !insertAlarm |=> dnData == $past(fifoData))
      else $error("data altered without alarm");
   ones_status_a: assert property (
      !rst |=> state_q.unframed_all_ones_status == $past(unframedAllOnesIn))
      else $error("all-ones status wrong");
   loss_status_a: assert property (
      !rst |=> state_q.signalLossStatus == $past(signal_loss_input_pin))
      else $error("loss status wrong");
   ones_flag_a: assert property (
      !rst && unframedAllOnesIn != state_q.unframed_all_ones_status
      |=> state_q.unframed_all_ones_change_flag)
      else $error("all-ones change not latched");
   loss_flag_a: assert property (
      !rst && signal_loss_input_pin != state_q.signalLossStatus
      |=> state_q.signal_loss_change_flag)
      else $error("loss change not latched");
   ones_irq_a: assert property (
      state_q.unframed_all_ones_change_flag && state_q.unframed_all_ones_irq_enable
      |=> irqReq)
      else $error("all-ones irq missing");
   loss_irq_a: assert property (
      state_q.signal_loss_change_flag && state_q.signal_loss_irq_enable |=> irqReq)
      else $error("loss irq missing");
   irq_quiet_a: assert property (
      !(state_q.signal_loss_change_flag && state_q.signal_loss_irq_enable) &&
      !(state_q.unframed_all_ones_change_flag && state_q.unframed_all_ones_irq_enable)
      |=> !irqReq)
      else $error("irq without enabled flag");
   flag_hold_a: assert property (
      state_q.signal_loss_change_flag && !wrDone |=> state_q.signal_loss_change_flag)
      else $error("loss flag dropped without clear");
   ones_hold_a: assert property (
      state_q.unframed_all_ones_change_flag && !wrDone
      |=> state_q.unframed_all_ones_change_flag)
      else $error("all-ones flag dropped without clear");
   ones_clear_a: assert property (
      wrDone && hits(paddr, RX_CLEAR_CHANNEL_LATCHED_STATUS) &&
      wrBits[UNFRAMED_ALL_ONES_BIT] &&
      unframedAllOnesIn == state_q.unframed_all_ones_status
      |=> !state_q.unframed_all_ones_change_flag)
      else $error("all-ones flag not cleared by write");
   loss_clear_a: assert property (
      wrDone && hits(paddr, RX_CLEAR_CHANNEL_LATCHED_STATUS) &&
      wrBits[SIGNAL_LOSS_BIT] &&
      signal_loss_input_pin == state_q.signalLossStatus
      |=> !state_q.signal_loss_change_flag)
      else $error("loss flag not cleared by write");

   // ----------------------------------------------------------------
   // Checks: data path
   // ----------------------------------------------------------------
   // A stalled word must not change under the sink, alarm or not
   out_hold_a: assert property (dnValid && !dnReady |=> dnValid && $stable(dnData))
      else $error("downstream word changed while stalled");

   alarm_seen_c: cover property (fifoPop && insertAlarm);
   irq_seen_c: cover property ($rose(irqReq));
   fifo_full_c: cover property (rxValid && !rxReady);
   flag_clear_c: cover property ($fell(state_q.unframed_all_ones_change_flag));
   slverr_seen_c: cover property (pslverr);
endmodule

// ---- cc_line_model.sv ----
// Line-side model: loss and all-ones detector levels plus the received word stream.
// Assumes the bench sets the levels and enables and that the block's rxReady follows valid/ready.
`timescale 1ns/1ns
module cc_line_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic genEn,
   input wire logic slow,
   input wire logic lossLevel,
   input wire logic onesLevel,
   input wire logic rxReady,
   output logic signal_loss_input_pin,
   output logic unframedAllOnesIn,
   output logic rxValid,
   output logic [7:0] rxData
);
   assign signal_loss_input_pin = lossLevel;
   assign unframedAllOnesIn = onesLevel;
   // ----------------------------------------------------------------
   // Word source
   // ----------------------------------------------------------------
   // Idle data toggles every cycle so a stale word never looks valid
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rxValid <= 1'b0;
         rxData <= 8'h00;
      end else if (rxValid && !rxReady) begin
         rxValid <= 1'b1;
      end else if (genEn && (!slow || ($urandom % 3 == 0))) begin
         rxValid <= 1'b1;
         rxData <= 8'($urandom);
      end else begin
         rxValid <= 1'b0;
         rxData <= ~rxData;
      end
   end
endmodule

// ---- clear_channel_rx_alarm_monitor_tb.sv ----
// Self-checking bench for the receive clear-channel alarm monitor.
// Assumes the line model drives the far side and the APB slave may add wait states.
`timescale 1ns/1ns
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] %0t mismatch got %h exp %h", $time, g, e); end end
module clear_channel_rx_alarm_monitor_tb;
   import cc_rx_alarm_pkg::*;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, dnReady = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, lossPin, onesPin, rxValid, rxReady, dnValid, irqReq;
   logic [7:0] rxData, dnData;
   logic genEn = 0, slow = 0, lossLvl = 0, onesLvl = 0, dnHold = 0, alarmNow = 0;
   int fails = 0, checkCount = 0, pushCount = 0;
   logic [32:0] rdQ[$];
   logic [7:0] dnQ[$];
   logic [3:0] modes[4] = '{4'b0000, 4'b0011, 4'b0110, 4'b1111};
   logic [15:0] mask;

   initial forever #4 clk = ~clk;

   cc_line_model cc_line_model_i (.clk(clk), .rst(rst), .genEn(genEn), .slow(slow),
      .lossLevel(lossLvl), .onesLevel(onesLvl), .rxReady(rxReady),
      .signal_loss_input_pin(lossPin), .unframedAllOnesIn(onesPin), .rxValid(rxValid),
      .rxData(rxData));
   cc_rx_alarm_monitor #(.DATA_W(8), .FIFO_DEPTH(16)) cc_rx_alarm_monitor_i (.clk(clk),
      .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .signal_loss_input_pin(lossPin), .unframedAllOnesIn(onesPin), .rxValid(rxValid),
      .rxReady(rxReady), .rxData(rxData), .dnValid(dnValid), .dnReady(dnReady),
      .dnData(dnData), .irqReq(irqReq));

   // ----------------------------------------------------------------
   // Drivers and bus tasks
   // ----------------------------------------------------------------
   always @(posedge clk) dnReady <= !dnHold && ($urandom % 4 != 0);

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
         input logic [32:0] e);
      @(posedge clk);
      rdQ.push_back(e);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Wait states are the slave's business; the watchdog ends a hang
      do begin @(posedge clk); end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      apb(a, 1'b0, 32'h0, {17'h0, e});
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      apb(a, 1'b1, {16'h0, d}, 33'h0);
   endtask

   // ----------------------------------------------------------------
   // Result watcher
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      logic [32:0] e;
      logic [7:0] want;
      if (psel && penable && pready === 1'b1) begin
         e = rdQ.pop_front();
         `CHK(pslverr, e[32])
         if (!pwrite) `CHK(prdata, e[31:0])
      end
      if (rxValid && rxReady === 1'b1) begin
         pushCount++;
         dnQ.push_back(alarmNow ? 8'hFF : rxData);
      end
      if (dnValid === 1'b1 && dnReady) begin
         if (dnQ.size() == 0) begin
            `CHK(1'b1, 1'b0)
         end else begin
            want = dnQ.pop_front();
            `CHK(dnData, want)
         end
      end
   end

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checkCount, fails);
      if (fails == 0 && checkCount > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_of_test();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h7A15BF2C));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd(RX_CLEAR_CHANNEL_CONTROL, REG_RESET);
      rd(RX_CLEAR_CHANNEL_LIVE_STATUS, REG_RESET);
      rd(RX_CLEAR_CHANNEL_LATCHED_STATUS, REG_RESET);
      rd(RX_CLEAR_CHANNEL_IRQ_ENABLE, REG_RESET);
      apb(8'h30, 1'b0, 32'h0, {1'b1, 32'h0});
      wr(RX_CLEAR_CHANNEL_LIVE_STATUS, 16'h0101);
      rd(RX_CLEAR_CHANNEL_LIVE_STATUS, 16'h0000);
      wr(RX_CLEAR_CHANNEL_CONTROL, 16'h1800);
      rd(RX_CLEAR_CHANNEL_CONTROL, 16'h1800);
      // Each detector: rise, enable, clear, fall, with the interrupt tracked
      for (int i = 0; i < 2; i++) begin
         mask = i ? 16'h0100 : 16'h0001;
         if (i) onesLvl <= 1'b1; else lossLvl <= 1'b1;
         repeat (3) @(posedge clk);
         `CHK(irqReq, 1'b0)
         rd(RX_CLEAR_CHANNEL_LIVE_STATUS, mask);
         rd(RX_CLEAR_CHANNEL_LATCHED_STATUS, mask);
         wr(RX_CLEAR_CHANNEL_IRQ_ENABLE, mask);
         repeat (3) @(posedge clk);
         `CHK(irqReq, 1'b1)
         wr(RX_CLEAR_CHANNEL_LATCHED_STATUS, mask);
         repeat (3) @(posedge clk);
         `CHK(irqReq, 1'b0)
         rd(RX_CLEAR_CHANNEL_LATCHED_STATUS, 16'h0000);
         if (i) onesLvl <= 1'b0; else lossLvl <= 1'b0;
         repeat (3) @(posedge clk);
         `CHK(irqReq, 1'b1)
         rd(RX_CLEAR_CHANNEL_LIVE_STATUS, 16'h0000);
         wr(RX_CLEAR_CHANNEL_LATCHED_STATUS, mask);
         wr(RX_CLEAR_CHANNEL_IRQ_ENABLE, 16'h0000);
      end
      // Alarm modes: manual, auto-disable, loss level, forced ones expected
      for (int i = 0; i < 4; i++) begin
         wr(RX_CLEAR_CHANNEL_CONTROL, {3'b000, modes[i][3:2], 11'h000});
         lossLvl <= modes[i][1];
         alarmNow = modes[i][0];
         repeat (4) @(posedge clk);
         slow <= i[0];
         genEn <= 1'b1;
         repeat (30) @(posedge clk);
         genEn <= 1'b0;
         for (int n = 0; n < 200 && (dnQ.size() != 0 || rxValid); n++) @(posedge clk);
         `CHK(dnQ.size(), 0)
      end
      // Fill with the downstream side stalled, then drain
      dnHold <= 1'b1;
      slow <= 1'b0;
      repeat (4) @(posedge clk);
      pushCount = 0;
      genEn <= 1'b1;
      repeat (60) @(posedge clk);
      `CHK(pushCount, FIFO_DEPTH + 1)
      `CHK(rxReady, 1'b0)
      genEn <= 1'b0;
      dnHold <= 1'b0;
      for (int n = 0; n < 300 && (dnQ.size() != 0 || rxValid); n++) @(posedge clk);
      `CHK(dnQ.size(), 0)
      // Reset in mid-run with the loss pin still high and the enables set
      wr(RX_CLEAR_CHANNEL_IRQ_ENABLE, 16'h0101);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK(rxReady, 1'b1)
      `CHK(dnValid, 1'b0)
      `CHK(irqReq, 1'b0)
      rst <= 1'b0;
      rd(RX_CLEAR_CHANNEL_IRQ_ENABLE, REG_RESET);
      rd(RX_CLEAR_CHANNEL_LIVE_STATUS, 16'h0001);
      rd(RX_CLEAR_CHANNEL_LATCHED_STATUS, 16'h0001);
      end_of_test();
   end
endmodule
